// >>> hdl/rmc_params.svh
// Register offsets, field positions, reset values, counter constants and queue depth for the multidrop control block
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH
`define RMC_CTRL_ADDR      32'h4000804C
`define RMC_ADDRESS_COMPARE_VALUE_ADDR  32'h40008050
`define RMC_DLY_ADDR       32'h40008054
`define RMC_BIT_MM_EN      0
`define RMC_BIT_RX_DIS     1
`define RMC_BIT_AAD_EN     2
`define RMC_BIT_PIN_SEL    3
`define RMC_BIT_DIR_EN     4
`define RMC_BIT_POL_INV    5
`define RMC_CTRL_W         6
`define RMC_CTRL_RST       6'h00
`define RMC_ADR_RST        8'h00
`define RMC_DLY_RST        8'h00
`define RMC_CNT_ZERO       8'h00
`define RMC_CNT_ONE        8'h01
`define RMC_FIFO_DEPTH     32
`endif

// >>> hdl/rmc_pkg.sv
// Types shared by the multidrop control block
package rmc_pkg;
   typedef enum logic [1:0] {
      RMC_DIR_IDLE = 2'b00,
      RMC_DIR_BUSY = 2'b01,
      RMC_DIR_HOLD = 2'b10
   } rmc_dir_e;
   typedef logic [8:0] rmc_char_t;
endpackage : rmc_pkg

// >>> hdl/rmc_stream_if.sv
// Valid/ready stream carrying nine-bit received characters between modules
`timescale 1ns/1ps
interface rmc_stream_if #(parameter int WIDTH = 9);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : rmc_stream_if

// >>> hdl/rmc_fifo.sv
// Receive queue: parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rmc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   rmc_stream_if.dst wr,
   rmc_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             do_wr;
   logic             do_rd;

   ////////////////////////////////////////////////////////////////////////
   // Handshakes; full stalls the writer, empty hides data
   assign wr.ready = (count != (AW+1)'(DEPTH));
   assign rd.valid = (count != '0);
   assign rd.data  = mem[rd_ptr];
   assign do_wr    = wr.valid && wr.ready;
   assign do_rd    = rd.valid && rd.ready;

   // Storage needs no reset
   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         mem[wr_ptr] <= wr.data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   a_fifo_no_overflow : assert property (@(posedge clk_sys) disable iff (!rst_b)
      count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : rmc_fifo

// >>> hdl/rmc_dir_timer.sv
// Direction pin sequencer with baud-timed turn-off delay
`timescale 1ns/1ps
`include "rmc_params.svh"
module rmc_dir_timer (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       tx_write,
   input  wire logic       tx_last_stop,
   input  wire logic       baud_tick,
   input  wire logic [7:0] delay_value,
   output logic            dir_active
);
   rmc_pkg::rmc_dir_e state;
   logic [7:0]        cnt;
   logic [7:0]        limit;

   ////////////////////////////////////////////////////////////////////////
   // eight-bit delay counter
   // A new write during the hold re-enters busy, so the pin never drops mid-burst
   // Delay is latched at the stop bit; a register write mid-hold cannot strand the count
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= rmc_pkg::RMC_DIR_IDLE;
         cnt   <= `RMC_CNT_ZERO;
         limit <= `RMC_DLY_RST;
      end else begin
         case (state)
            rmc_pkg::RMC_DIR_IDLE: begin
               if (tx_write) begin
                  state <= rmc_pkg::RMC_DIR_BUSY;
               end
            end
            rmc_pkg::RMC_DIR_BUSY: begin
               if (tx_last_stop && !tx_write) begin
                  cnt   <= `RMC_CNT_ZERO;
                  limit <= delay_value;
                  state <= (delay_value == `RMC_CNT_ZERO) ? rmc_pkg::RMC_DIR_IDLE
                                                          : rmc_pkg::RMC_DIR_HOLD;
               end
            end
            rmc_pkg::RMC_DIR_HOLD: begin
               if (tx_write) begin
                  state <= rmc_pkg::RMC_DIR_BUSY;
               end else if (baud_tick) begin
                  cnt <= cnt + `RMC_CNT_ONE;
                  if (cnt + `RMC_CNT_ONE >= limit) begin
                     state <= rmc_pkg::RMC_DIR_IDLE;
                  end
               end
            end
            default: state <= rmc_pkg::RMC_DIR_IDLE;
         endcase
      end
   end

   assign dir_active = (state != rmc_pkg::RMC_DIR_IDLE);

   a_hold_not_past_delay : assert property (@(posedge clk_sys) disable iff (!rst_b)
      state == rmc_pkg::RMC_DIR_HOLD |-> cnt < limit)
      else $error("hold counter passed delay");
endmodule : rmc_dir_timer

// >>> hdl/rmc_multidrop.sv
// Multidrop receive filter, address match and automatic direction control
`timescale 1ns/1ps
`include "rmc_params.svh"

module rmc_multidrop (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Register port
   input  wire logic [31:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   // Received characters from the shift register
   input  wire logic        rx_char_valid,
   input  wire logic [8:0]  rx_char,
   // Host side of the receive queue
   output logic             rxq_valid,
   output logic [8:0]       rxq_data,
   input  wire logic        rxq_pop,
   output logic             rxq_full,
   // Interrupt sources towards the interrupt interface
   output logic             rx_ready_pulse,
   output logic             parity_err_pulse,
   // Transmitter events
   input  wire logic        tx_write,
   input  wire logic        tx_last_stop,
   input  wire logic        baud_tick,
   // Modem control and loopback
   input  wire logic        loopback,
   input  wire logic        rts_modem,
   input  wire logic        dtr_modem,
   output logic             rts_pin,
   output logic             dtr_pin
);
   logic [`RMC_CTRL_W-1:0] ctrl;
   logic [7:0]             address_compare_value;
   logic [7:0]             turnoff_delay_value;
   logic                   manual_multidrop_enable;
   logic                   receiver_disable;
   logic                   auto_detect_enable;
   logic                   pin_sel;
   logic                   auto_direction_enable;
   logic                   direction_polarity_invert;
   logic                   automatic_address_detect;
   logic                   is_addr;
   logic                   addr_match;
   logic                   accept;
   logic                   hw_clear_dis;
   logic                   hw_set_dis;
   logic                   fifo_out_valid;
   logic [8:0]             fifo_out_data;
   logic                   dir_active;
   logic                   dir_level;
   logic                   next_rts;
   logic                   next_dtr;

   rmc_stream_if #(.WIDTH(9)) push_s ();
   rmc_stream_if #(.WIDTH(9)) pop_s ();

   assign manual_multidrop_enable   = ctrl[`RMC_BIT_MM_EN];
   assign receiver_disable          = ctrl[`RMC_BIT_RX_DIS];
   assign auto_detect_enable        = ctrl[`RMC_BIT_AAD_EN];
   assign pin_sel                   = ctrl[`RMC_BIT_PIN_SEL];
   assign auto_direction_enable     = ctrl[`RMC_BIT_DIR_EN];
   assign direction_polarity_invert = ctrl[`RMC_BIT_POL_INV];

   ////////////////////////////////////////////////////////////////////////
   // Character classification
   // automatic detect needs both bits
   assign automatic_address_detect = manual_multidrop_enable && auto_detect_enable;
   assign is_addr    = rx_char[8];
   assign addr_match = is_addr && (rx_char[7:0] == address_compare_value);

   // Acceptance decision per mode
   always_comb begin
      accept       = 1'b1;
      hw_clear_dis = 1'b0;
      hw_set_dis   = 1'b0;
      if (automatic_address_detect) begin
         if (receiver_disable) begin
            accept       = addr_match;
            hw_clear_dis = rx_char_valid && addr_match;
         end else if (is_addr && !addr_match) begin
            accept     = 1'b0;
            hw_set_dis = rx_char_valid;
         end
      end else if (manual_multidrop_enable && receiver_disable) begin
         accept = is_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive queue; a full queue simply loses the character, as an overrun would
   assign push_s.valid = rx_char_valid && accept;
   assign push_s.data  = rx_char;
   assign pop_s.ready  = rxq_pop;

   rmc_fifo #(.WIDTH(9), .DEPTH(`RMC_FIFO_DEPTH)) u_rx_fifo (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .wr      (push_s),
      .rd      (pop_s)
   );

   assign fifo_out_valid = pop_s.valid;
   assign fifo_out_data  = pop_s.data;

   // Registered view of queue head so top outputs come from flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rxq_valid <= 1'b0;
         rxq_data  <= '0;
         rxq_full  <= 1'b0;
      end else begin
         rxq_valid <= fifo_out_valid && !rxq_pop;
         rxq_data  <= fifo_out_data;
         rxq_full  <= !push_s.ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt event pulses
   // address flagged as parity error
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         parity_err_pulse <= 1'b0;
         rx_ready_pulse   <= 1'b0;
      end else begin
         parity_err_pulse <= rx_char_valid && manual_multidrop_enable && is_addr
                             && accept;
         rx_ready_pulse   <= push_s.valid && push_s.ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes; hardware update of the disable bit beats a software write
   // control bits reset zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= `RMC_CTRL_RST;
      end else begin
         if (reg_wr && reg_addr == `RMC_CTRL_ADDR) begin
            ctrl <= reg_wdata[`RMC_CTRL_W-1:0];
         end
         if (hw_clear_dis) begin
            ctrl[`RMC_BIT_RX_DIS] <= 1'b0;
         end else if (hw_set_dis) begin
            ctrl[`RMC_BIT_RX_DIS] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         address_compare_value <= `RMC_ADR_RST;
      end else if (reg_wr && reg_addr == `RMC_ADDRESS_COMPARE_VALUE_ADDR) begin
         address_compare_value <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         turnoff_delay_value <= `RMC_DLY_RST;
      end else if (reg_wr && reg_addr == `RMC_DLY_ADDR) begin
         turnoff_delay_value <= reg_wdata[7:0];
      end
   end

   // Read data, registered; reserved bits read zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else begin
         case (reg_addr)
            `RMC_CTRL_ADDR:     reg_rdata <= {26'h0000000, ctrl};
            `RMC_ADDRESS_COMPARE_VALUE_ADDR: reg_rdata <= {24'h000000, address_compare_value};
            `RMC_DLY_ADDR:      reg_rdata <= {24'h000000, turnoff_delay_value};
            default:            reg_rdata <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Direction control
   rmc_dir_timer u_dir (
      .clk_sys      (clk_sys),
      .rst_b        (rst_b),
      .tx_write     (tx_write),
      .tx_last_stop (tx_last_stop),
      .baud_tick    (baud_tick),
      .delay_value  (turnoff_delay_value),
      .dir_active   (dir_active)
   );

   assign dir_level = direction_polarity_invert ? dir_active : !dir_active;

   always_comb begin
      next_rts = rts_modem;
      next_dtr = dtr_modem;
      if (auto_direction_enable && !loopback) begin
         if (pin_sel) begin
            next_dtr = dir_level;
         end else begin
            next_rts = dir_level;
         end
      end
   end

   // Pins registered; one cycle of latency is far below a bit time
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rts_pin <= 1'b1;
         dtr_pin <= 1'b1;
      end else begin
         rts_pin <= next_rts;
         dtr_pin <= next_dtr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_mismatch_enabled;
      rx_char_valid && automatic_address_detect && !receiver_disable
      && is_addr && !addr_match;
   endsequence

   sequence s_match_disabled;
      rx_char_valid && automatic_address_detect && receiver_disable && addr_match;
   endsequence

   a_mismatch_sets_dis : assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_mismatch_enabled |=> receiver_disable)
      else $error("mismatch did not disable receiver");
   a_mismatch_not_kept : assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_mismatch_enabled |=> !rx_ready_pulse)
      else $error("mismatched address stored");
   a_match_clears_dis : assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_match_disabled |=> !receiver_disable)
      else $error("match did not enable receiver");
   a_match_data_ready : assert property (@(posedge clk_sys) disable iff (!rst_b)
      (s_match_disabled and push_s.ready) |=> rx_ready_pulse)
      else $error("match gave no data-ready");
   a_auto_drop_data : assert property (@(posedge clk_sys) disable iff (!rst_b)
      rx_char_valid && automatic_address_detect && receiver_disable && !is_addr
      |=> !rx_ready_pulse)
      else $error("data stored while disabled");
   a_manual_drop_data : assert property (@(posedge clk_sys) disable iff (!rst_b)
      rx_char_valid && manual_multidrop_enable && !auto_detect_enable
      && receiver_disable && !is_addr |=> !rx_ready_pulse)
      else $error("manual mode stored data while disabled");
   a_manual_addr_kept : assert property (@(posedge clk_sys) disable iff (!rst_b)
      rx_char_valid && manual_multidrop_enable && !auto_detect_enable && is_addr
      && push_s.ready |=> rx_ready_pulse && parity_err_pulse)
      else $error("manual address not stored or flagged");
   a_enabled_keeps_all : assert property (@(posedge clk_sys) disable iff (!rst_b)
      rx_char_valid && manual_multidrop_enable && !receiver_disable && !is_addr
      && push_s.ready |=> rx_ready_pulse)
      else $error("enabled receiver dropped data");
   a_dir_rts_drive : assert property (@(posedge clk_sys) disable iff (!rst_b)
      auto_direction_enable && !loopback && !pin_sel
      |=> rts_pin == $past(dir_level))
      else $error("rts not following direction");
   a_dir_write_asserts : assert property (@(posedge clk_sys) disable iff (!rst_b)
      tx_write && auto_direction_enable && !loopback && !pin_sel
      && !direction_polarity_invert ##1 auto_direction_enable && !loopback
      && !pin_sel && !direction_polarity_invert |=> !rts_pin)
      else $error("write did not assert direction");
   a_dir_off_passthru : assert property (@(posedge clk_sys) disable iff (!rst_b)
      !auto_direction_enable |=> dtr_pin == $past(dtr_modem))
      else $error("direction driven while disabled");
endmodule : rmc_multidrop

// >>> bench/rmc_bus_master.sv
// Multidrop bus master model that hands received nine-bit characters to the block
`timescale 1ns/1ps
module rmc_bus_master (
   input  wire logic  clk_sys,
   output logic       rx_char_valid,
   output logic [8:0] rx_char
);
   // Nothing offered before the first character
   initial begin
      rx_char_valid = 1'B0;
      rx_char       = 9'H0AA;
   end
   // Offer one character after an idle gap; stale data is inverted so it is never reused
   // bit 8 marks address
   task automatic send(input logic [8:0] c, input int gap);
      repeat (gap) @(posedge clk_sys);
      @(posedge clk_sys);
      rx_char_valid <= 1'B1;
      rx_char       <= c;
      @(posedge clk_sys);
      rx_char_valid <= 1'B0;
      rx_char       <= ~c;
   endtask : send
endmodule : rmc_bus_master

// >>> bench/tb_top.sv
// Self-checking testbench for the multidrop control block
`timescale 1ns/1ps
`include "rmc_params.svh"
module tb_top;
   logic clk_sys, rst_b, reg_wr, rx_char_valid, rxq_valid, rxq_pop, rxq_full;
   logic rx_ready_pulse, parity_err_pulse, tx_write, tx_last_stop, baud_tick;
   logic loopback, rts_modem, dtr_modem, rts_pin, dtr_pin;
   logic [31:0] reg_addr, reg_wdata, reg_rdata;
   logic [8:0]  rx_char, rxq_data;
   logic [8:0]  exp_q[$];
   logic [31:0] seed;
   int          miscompares, compares;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 50 MHz
   initial begin
      clk_sys = 1'B0;
      forever #10 clk_sys = ~clk_sys;
   end

   rmc_bus_master bm (.clk_sys(clk_sys), .rx_char_valid(rx_char_valid), .rx_char(rx_char));

   rmc_multidrop dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .rxq_valid(rxq_valid), .rxq_data(rxq_data), .rxq_pop(rxq_pop),
      .rxq_full(rxq_full), .rx_ready_pulse(rx_ready_pulse),
      .parity_err_pulse(parity_err_pulse), .tx_write(tx_write),
      .tx_last_stop(tx_last_stop), .baud_tick(baud_tick), .loopback(loopback),
      .rts_modem(rts_modem), .dtr_modem(dtr_modem), .rts_pin(rts_pin), .dtr_pin(dtr_pin)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Fixed-seed xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results

   // Register write, taken at the edge that sees the strobe
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'B1;
      @(posedge clk_sys);
      reg_wr    <= 1'B0;
   endtask : wr

   // Register read, data one edge after the address
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      @(posedge clk_sys);
      #1 chk("reg_rdata", e, reg_rdata);
   endtask : rd

   // One character through the filter; the model keeps what should be stored
   task automatic rx(input logic [8:0] c, input logic st, input logic pe, input int gap);
      bm.send(c, gap);
      // Pulses stand for the one cycle after the taking edge
      #1 chk("rx_ready_pulse", {31'H0, st}, {31'H0, rx_ready_pulse});
      chk("parity_err_pulse", {31'H0, pe}, {31'H0, parity_err_pulse});
      if (st) exp_q.push_back(c);
   endtask : rx

   // Empty the queue, comparing each head; stop after a quiet spell
   task automatic drain();
      int n;
      n = 0;
      while (n < 8) begin
         @(posedge clk_sys);
         #1;
         if (rxq_valid === 1'B1 && exp_q.size() > 0) begin
            chk("rxq_data", {23'H0, exp_q.pop_front()}, {23'H0, rxq_data});
            @(posedge clk_sys);
            rxq_pop <= 1'B1;
            @(posedge clk_sys);
            rxq_pop <= 1'B0;
            n = 0;
         end else n++;
      end
      chk("rxq_valid", 32'H0, {31'H0, rxq_valid});
      chk("left", 32'H0, exp_q.size());
   endtask : drain

   // One-cycle pulse on a transmitter event: 0 write, 1 last stop, 2 baud
   task automatic pulse(input int w);
      @(posedge clk_sys);
      if (w == 0) tx_write <= 1'B1;
      else if (w == 1) tx_last_stop <= 1'B1;
      else baud_tick <= 1'B1;
      @(posedge clk_sys);
      tx_write     <= 1'B0;
      tx_last_stop <= 1'B0;
      baud_tick    <= 1'B0;
   endtask : pulse

   // Selected pin shows lvl, the other follows its modem level
   task automatic pins(input logic sel, input logic lvl);
      chk("rts_pin", {31'H0, sel ? rts_modem : lvl}, {31'H0, rts_pin});
      chk("dtr_pin", {31'H0, sel ? lvl : dtr_modem}, {31'H0, dtr_pin});
   endtask : pins

   // Full direction cycle, optionally restarted during the hold
   task automatic dir(input logic sel, input logic inv, input int d, input logic rs);
      wr(`RMC_CTRL_ADDR, {26'H0, inv, 1'B1, sel, 3'H0});
      wr(`RMC_DLY_ADDR, d);
      pulse(0);
      repeat (2) @(posedge clk_sys);
      #1 pins(sel, inv);
      pulse(1);
      if (rs) begin
         pulse(2);
         pulse(0);
         repeat (2) @(posedge clk_sys);
         #1 pins(sel, inv);
         pulse(1);
      end
      for (int i = 0; i < d; i++) begin
         if (i == d - 1) begin
            repeat (2) @(posedge clk_sys);
            #1 pins(sel, inv);
         end
         pulse(2);
      end
      repeat (2) @(posedge clk_sys);
      #1 pins(sel, ~inv);
   endtask : dir

   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard
   initial begin
      repeat (30000) @(posedge clk_sys);
      miscompares++;
      results();
   end

   // Main sequence
   initial begin
      logic [8:0] c;
      seed = 32'H40;
      rst_b = 1'B0; reg_addr = 32'H0; reg_wr = 1'B0; reg_wdata = 32'H0; rxq_pop = 1'B0;
      tx_write = 1'B0; tx_last_stop = 1'B0; baud_tick = 1'B0; loopback = 1'B0;
      rts_modem = 1'B1; dtr_modem = 1'B1;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'B1;
      rd(`RMC_CTRL_ADDR, 32'H0);
      rd(`RMC_ADDRESS_COMPARE_VALUE_ADDR, 32'H0);
      rd(`RMC_DLY_ADDR, 32'H0);
      rd(32'H40008058, 32'H0);
      wr(`RMC_ADDRESS_COMPARE_VALUE_ADDR, 32'H5A);
      rd(`RMC_ADDRESS_COMPARE_VALUE_ADDR, 32'H5A);
      // Manual mode, receiver off then on
      wr(`RMC_CTRL_ADDR, 32'H3);
      rx(9'H011, 1'B0, 1'B0, 0);
      rx(9'H155, 1'B1, 1'B1, 0);
      drain();
      wr(`RMC_CTRL_ADDR, 32'H1);
      rx(9'H022, 1'B1, 1'B0, 0);
      rx(9'H133, 1'B1, 1'B1, 0);
      drain();
      // Automatic detection
      wr(`RMC_CTRL_ADDR, 32'H7);
      rx(9'H05A, 1'B0, 1'B0, 0);
      rx(9'H1A5, 1'B0, 1'B0, 0);
      rx(9'H15A, 1'B1, 1'B1, 0);
      rd(`RMC_CTRL_ADDR, 32'H5);
      rx(9'H0C3, 1'B1, 1'B0, 0);
      rx(9'H1A5, 1'B0, 1'B0, 0);
      rd(`RMC_CTRL_ADDR, 32'H7);
      rx(9'H0C3, 1'B0, 1'B0, 0);
      drain();
      // Random traffic overfills the queue; the extra character is lost
      wr(`RMC_CTRL_ADDR, 32'H1);
      for (int i = 0; i < 33; i++) begin
         c = 9'(rnd());
         rx(c, i < 32, c[8], rnd() % 3);
      end
      chk("rxq_full", 32'H1, {31'H0, rxq_full});
      drain();
      // Direction: pin choice, polarity, delay bounds, restart
      dir(1'B0, 1'B0, 3, 1'B0);
      dir(1'B1, 1'B1, 0, 1'B0);
      dir(1'B0, 1'B1, 2, 1'B1);
      dir(1'B1, 1'B0, 255, 1'B0);
      // Disabled or loopback: modem levels stay on the pins
      wr(`RMC_CTRL_ADDR, 32'H0);
      pulse(0);
      repeat (2) @(posedge clk_sys);
      #1 pins(1'B0, rts_modem);
      pulse(1);
      wr(`RMC_CTRL_ADDR, 32'H10);
      loopback <= 1'B1;
      pulse(0);
      repeat (2) @(posedge clk_sys);
      #1 pins(1'B0, rts_modem);
      pulse(1);
      results();
   end
endmodule : tb_top
